//--- inc/mafe_pkg.sv
// Purpose: Shared constants and carrier types of the measurement front end register bank.
// Assumes: Register addresses are the four-bit addresses seen on the serial host port.
// Notes: Every width, field position and mode code lives here, with reset values for the mode, channel, general, threshold and test registers.

package mafe_pkg;

    // ************************************************************
    // Register addresses and widths
    // ************************************************************
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CHAN_A = 4'h1;
    localparam logic [3:0] ADDR_CHAN_B = 4'h2;
    localparam logic [3:0] ADDR_GENERAL = 4'h3;
    localparam logic [3:0] ADDR_RESULT = 4'h4;
    localparam logic [3:0] ADDR_FUSE = 4'h5;
    localparam logic [3:0] ADDR_CAL = 4'h6;
    localparam logic [3:0] ADDR_TRIM = 4'h7;
    localparam logic [3:0] ADDR_THRESHOLD = 4'h8;
    localparam logic [3:0] ADDR_TEST_CFG = 4'h9;

    localparam int SHIFT_W = 188;
    localparam logic [7:0] W_MODE = 8'h04;
    localparam logic [7:0] W_CHAN = 8'h11;
    localparam logic [7:0] W_GENERAL = 8'h1c;
    localparam logic [7:0] W_RESULT = 8'h12;
    localparam logic [7:0] W_FUSE = 8'hbc;
    localparam logic [7:0] W_CAL = 8'h6e;
    localparam logic [7:0] W_TRIM = 8'h14;
    localparam logic [7:0] W_THRESHOLD = 8'h11;
    localparam logic [7:0] W_TEST_CFG = 8'h14;
    localparam logic [7:0] W_NONE = 8'h00;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [16:0] RST_CHAN_A = 17'h003c0;
    localparam logic [16:0] RST_CHAN_B = 17'h018c0;
    localparam logic [27:0] RST_GENERAL = 28'h1c00004;
    localparam logic [16:0] RST_THRESHOLD = 17'h00000;
    localparam logic [19:0] RST_TEST_CFG = 20'h00000;

    // ************************************************************
    // General configuration field layout
    // ************************************************************
    localparam int SEQ_CHOP_LSB = 22;
    localparam int CURRENT_LSB = 11;
    localparam int VROUTE_LSB = 7;
    localparam int PD_LSB = 0;
    localparam int SEQ_LEN_LSB = 2;
    localparam int DECHOP_BIT = 1;
    localparam int CHOP_BIT = 0;
    localparam int MUX_LSB = 5;
    localparam int CSRC_LSB = 0;
    localparam logic [4:0] SEQ_LEN_ZERO_CODE = 5'h10;
    localparam logic [3:0] CSRC_STEP_UA = 4'h8;

    // ************************************************************
    // Operating modes
    // ************************************************************
    localparam logic [3:0] MODE_FUSE_LOAD = 4'h0;
    localparam logic [3:0] MODE_SINGLE = 4'h1;
    localparam logic [3:0] MODE_DUAL = 4'h2;
    localparam logic [3:0] MODE_WAKEUP = 4'h3;
    localparam logic [3:0] MODE_ALARM = 4'h4;
    localparam logic [3:0] MODE_FUSE_PROG = 4'h5;
    localparam logic [3:0] MODE_POWERDOWN = 4'h6;
    localparam logic [3:0] MODE_INT_CLOCK = 4'h7;
    localparam logic [3:0] MODE_TEST_SPECIAL = 4'h8;
    localparam int MODE_TEST_BIT = 3;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic start;
        logic addr_valid;
        logic [3:0] addr;
        logic write;
        logic shift;
        logic din;
        logic stop;
    } mafe_host_req_t;

    typedef struct packed {
        logic [4:0] seq_len;
        logic dechop_en;
        logic chop_en;
        logic [5:0] mux_sw;
        logic [4:0] csrc_code;
        logic [7:0] csrc_ua;
        logic [3:0] vbus_sw;
        logic [6:0] pd;
    } mafe_gen_ctl_t;

    typedef struct packed {
        logic fuse_load;
        logic single_meas;
        logic dual_meas;
        logic wakeup;
        logic alarm;
        logic fuse_prog;
        logic powerdown;
        logic internal_clock;
        logic test;
    } mafe_mode_dec_t;

endpackage

//--- hdl/mafe_cfg_decode.sv
// Purpose: Registered decode of the operating mode and the general configuration word.
// Assumes: Inputs come from registers on the same clock.
// Notes: Outputs lag the register contents by one clock.

`timescale 1ns/1ps

module mafe_cfg_decode (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] mode_in,
    input wire logic [27:0] general_in,
    output mafe_pkg::mafe_gen_ctl_t gen_ctl_out,
    output mafe_pkg::mafe_mode_dec_t mode_dec_out
);

    mafe_pkg::mafe_gen_ctl_t gen_ff;
    mafe_pkg::mafe_gen_ctl_t nxt_gen;
    mafe_pkg::mafe_mode_dec_t mode_ff;
    mafe_pkg::mafe_mode_dec_t nxt_mode;

    // ************************************************************
    // Decode
    // ************************************************************
    always_comb begin
        logic [5:0] seq_chop;
        logic [10:0] cur;
        logic [3:0] len_code;
        seq_chop = general_in[mafe_pkg::SEQ_CHOP_LSB +: 6];
        cur = general_in[mafe_pkg::CURRENT_LSB +: 11];
        len_code = seq_chop[mafe_pkg::SEQ_LEN_LSB +: 4];
        nxt_mode = '0;
        nxt_mode.test = mode_in[mafe_pkg::MODE_TEST_BIT];
        case (mode_in)
            mafe_pkg::MODE_FUSE_LOAD: nxt_mode.fuse_load = 1'b1;
            mafe_pkg::MODE_SINGLE: nxt_mode.single_meas = 1'b1;
            mafe_pkg::MODE_DUAL: nxt_mode.dual_meas = 1'b1;
            mafe_pkg::MODE_WAKEUP: nxt_mode.wakeup = 1'b1;
            mafe_pkg::MODE_ALARM: nxt_mode.alarm = 1'b1;
            mafe_pkg::MODE_FUSE_PROG: nxt_mode.fuse_prog = 1'b1;
            mafe_pkg::MODE_POWERDOWN: nxt_mode.powerdown = 1'b1;
            mafe_pkg::MODE_INT_CLOCK: nxt_mode.internal_clock = 1'b1;
            default: nxt_mode.test = 1'b1;
        endcase
        // Outside dual mode the length reads as zero so nothing downstream acts on it.
        if (mode_in != mafe_pkg::MODE_DUAL) begin
            nxt_gen.seq_len = 5'h00;
        end else if (len_code == 4'h0) begin
            nxt_gen.seq_len = mafe_pkg::SEQ_LEN_ZERO_CODE;
        end else begin
            nxt_gen.seq_len = {1'b0, len_code};
        end
        nxt_gen.dechop_en = seq_chop[mafe_pkg::DECHOP_BIT];
        nxt_gen.chop_en = seq_chop[mafe_pkg::CHOP_BIT];
        nxt_gen.mux_sw = cur[mafe_pkg::MUX_LSB +: 6];
        nxt_gen.csrc_code = cur[mafe_pkg::CSRC_LSB +: 5];
        nxt_gen.csrc_ua = 8'(cur[mafe_pkg::CSRC_LSB +: 5]) * mafe_pkg::CSRC_STEP_UA;
        nxt_gen.vbus_sw = general_in[mafe_pkg::VROUTE_LSB +: 4];
        nxt_gen.pd = general_in[mafe_pkg::PD_LSB +: 7];
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gen_ff <= '0;
            mode_ff <= '0;
        end else begin
            gen_ff <= nxt_gen;
            mode_ff <= nxt_mode;
        end
    end

    assign gen_ctl_out = gen_ff;
    assign mode_dec_out = mode_ff;

endmodule

//--- hdl/mafe_register_bank.sv
// Purpose: Register bank of the measurement front end behind the serial host port.
// Assumes: The serial engine on the same clock delivers start, address, bit and stop strobes.
// Notes: Bits are shifted most significant first; shadowed registers update at stop.
//
// Operation
// - Register contents drive all functions; host may rewrite mode, channel, general and threshold registers anytime.
// - Decode addresses 0 to 9 with their documented register widths.
// - Test configuration writes act only in operating mode eight.
// - Unsupported writes are dropped; normal operation resumes at next start.
// - Calibration and trimming have no shadow; shifted bits act at once.
// - Operating mode register is four bits and resets to zero.
// - General configuration splits into fields at 27-22, 21-11, 10-7, 6-0.
// - Sequence length code n means n measurements, zero means 16, reset 1.
// - Sequence length matters only in dual alternating mode.
// - Dechop bit 1 and chop bit 0 enable when set, both reset set.
// - Current field bits 10 to 5 are input switches, reset zero.
// - Five-bit current code selects code times 8 uA.
// - Switch bits are positive logic: one closes the switch.
// - Voltage routing bits close voltage bus switches, reset zero.
// - Power-down bits each power a block down; only current source resets set.
// - Mode codes 0 to 7 decode to named modes; top bit means test.

`timescale 1ns/1ps

module mafe_register_bank (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input mafe_pkg::mafe_host_req_t host_in,
    input wire logic [17:0] result_in,
    input wire logic result_valid_in,
    output logic dout_out,
    output logic [3:0] mode_out,
    output logic [16:0] chan_a_out,
    output logic [16:0] chan_b_out,
    output logic [16:0] threshold_out,
    output logic [19:0] test_cfg_out,
    output logic [187:0] fuse_image_out,
    output logic [109:0] cal_out,
    output logic [19:0] trim_out,
    output mafe_pkg::mafe_gen_ctl_t gen_ctl_out,
    output mafe_pkg::mafe_mode_dec_t mode_dec_out
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] reg_width(input logic [3:0] addr);
        case (addr)
            mafe_pkg::ADDR_MODE: reg_width = mafe_pkg::W_MODE;
            mafe_pkg::ADDR_CHAN_A: reg_width = mafe_pkg::W_CHAN;
            mafe_pkg::ADDR_CHAN_B: reg_width = mafe_pkg::W_CHAN;
            mafe_pkg::ADDR_GENERAL: reg_width = mafe_pkg::W_GENERAL;
            mafe_pkg::ADDR_RESULT: reg_width = mafe_pkg::W_RESULT;
            mafe_pkg::ADDR_FUSE: reg_width = mafe_pkg::W_FUSE;
            mafe_pkg::ADDR_CAL: reg_width = mafe_pkg::W_CAL;
            mafe_pkg::ADDR_TRIM: reg_width = mafe_pkg::W_TRIM;
            mafe_pkg::ADDR_THRESHOLD: reg_width = mafe_pkg::W_THRESHOLD;
            mafe_pkg::ADDR_TEST_CFG: reg_width = mafe_pkg::W_TEST_CFG;
            default: reg_width = mafe_pkg::W_NONE;
        endcase
    endfunction

    function automatic logic is_test_mode(input logic [3:0] mode);
        is_test_mode = mode[mafe_pkg::MODE_TEST_BIT];
    endfunction

    // ************************************************************
    // Transaction state
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_READ = 5'b01000,
        ST_SKIP = 5'b10000
    } mafe_state_t;

    mafe_state_t state_ff;
    mafe_state_t nxt_state;
    logic [3:0] addr_ff;
    logic [3:0] nxt_addr;
    logic [mafe_pkg::SHIFT_W-1:0] shift_ff;
    logic [mafe_pkg::SHIFT_W-1:0] nxt_shift;

    logic [3:0] mode_ff;
    logic [3:0] nxt_mode;
    logic [16:0] chan_a_ff;
    logic [16:0] nxt_chan_a;
    logic [16:0] chan_b_ff;
    logic [16:0] nxt_chan_b;
    logic [27:0] general_ff;
    logic [27:0] nxt_general;
    logic [17:0] result_ff;
    logic [17:0] nxt_result;
    logic [187:0] fuse_ff;
    logic [187:0] nxt_fuse;
    logic [109:0] cal_ff;
    logic [109:0] nxt_cal;
    logic [19:0] trim_ff;
    logic [19:0] nxt_trim;
    logic [16:0] threshold_ff;
    logic [16:0] nxt_threshold;
    logic [19:0] test_cfg_ff;
    logic [19:0] nxt_test_cfg;

    // A write is accepted only where the current mode allows it.
    function automatic logic write_allowed(input logic [3:0] addr, input logic [3:0] mode);
        case (addr)
            mafe_pkg::ADDR_MODE: write_allowed = 1'b1;
            mafe_pkg::ADDR_CHAN_A: write_allowed = 1'b1;
            mafe_pkg::ADDR_CHAN_B: write_allowed = 1'b1;
            mafe_pkg::ADDR_GENERAL: write_allowed = 1'b1;
            mafe_pkg::ADDR_THRESHOLD: write_allowed = 1'b1;
            mafe_pkg::ADDR_FUSE: write_allowed = is_test_mode(mode) ||
                (mode == mafe_pkg::MODE_FUSE_PROG);
            mafe_pkg::ADDR_CAL: write_allowed = is_test_mode(mode);
            mafe_pkg::ADDR_TRIM: write_allowed = is_test_mode(mode);
            mafe_pkg::ADDR_TEST_CFG: write_allowed =
                (mode == mafe_pkg::MODE_TEST_SPECIAL);
            default: write_allowed = 1'b0;
        endcase
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [mafe_pkg::SHIFT_W-1:0] rd_word;
        logic [7:0] width;
        rd_word = '0;
        width = reg_width(host_in.addr);
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_shift = shift_ff;
        nxt_mode = mode_ff;
        nxt_chan_a = chan_a_ff;
        nxt_chan_b = chan_b_ff;
        nxt_general = general_ff;
        nxt_result = result_ff;
        nxt_fuse = fuse_ff;
        nxt_cal = cal_ff;
        nxt_trim = trim_ff;
        nxt_threshold = threshold_ff;
        nxt_test_cfg = test_cfg_ff;

        // The measurement path keeps the result fresh regardless of host traffic.
        if (result_valid_in) begin
            nxt_result = result_in;
        end

        case (addr_ff)
            mafe_pkg::ADDR_MODE: rd_word[3:0] = mode_ff;
            mafe_pkg::ADDR_CHAN_A: rd_word[16:0] = chan_a_ff;
            mafe_pkg::ADDR_CHAN_B: rd_word[16:0] = chan_b_ff;
            mafe_pkg::ADDR_GENERAL: rd_word[27:0] = general_ff;
            mafe_pkg::ADDR_RESULT: rd_word[17:0] = result_ff;
            mafe_pkg::ADDR_FUSE: rd_word = fuse_ff;
            mafe_pkg::ADDR_CAL: rd_word[109:0] = cal_ff;
            mafe_pkg::ADDR_TRIM: rd_word[19:0] = trim_ff;
            mafe_pkg::ADDR_THRESHOLD: rd_word[16:0] = threshold_ff;
            mafe_pkg::ADDR_TEST_CFG: rd_word[19:0] = test_cfg_ff;
            default: rd_word = '0;
        endcase

        case (state_ff)
            ST_IDLE: begin
                nxt_state = ST_IDLE;
            end
            ST_ADDR: begin
                if (host_in.addr_valid) begin
                    nxt_addr = host_in.addr;
                    nxt_shift = '0;
                    if (!host_in.write) begin
                        nxt_state = ST_READ;
                    end else if (write_allowed(host_in.addr, mode_ff)) begin
                        nxt_state = ST_WRITE;
                    end else begin
                        // Write not allowed in the current mode; the frame is skipped and nothing is stored.
                        nxt_state = ST_SKIP;
                    end
                end
            end
            ST_READ: begin
                // The word is left aligned once the address has settled.
                if (shift_ff == '0 && !host_in.shift) begin
                    nxt_shift = rd_word << (mafe_pkg::SHIFT_W - int'(reg_width(addr_ff)));
                end else if (host_in.shift) begin
                    nxt_shift = {shift_ff[mafe_pkg::SHIFT_W-2:0], 1'b0};
                end
            end
            ST_WRITE: begin
                if (host_in.shift) begin
                    nxt_shift = {shift_ff[mafe_pkg::SHIFT_W-2:0], host_in.din};
                    // Unshadowed: every bit reaches the analog controls immediately.
                    if (addr_ff == mafe_pkg::ADDR_CAL) begin
                        nxt_cal = {cal_ff[108:0], host_in.din};
                    end
                    if (addr_ff == mafe_pkg::ADDR_TRIM) begin
                        nxt_trim = {trim_ff[18:0], host_in.din};
                    end
                end
                if (host_in.stop) begin
                    case (addr_ff)
                        mafe_pkg::ADDR_MODE: nxt_mode = shift_ff[3:0];
                        mafe_pkg::ADDR_CHAN_A: nxt_chan_a = shift_ff[16:0];
                        mafe_pkg::ADDR_CHAN_B: nxt_chan_b = shift_ff[16:0];
                        mafe_pkg::ADDR_GENERAL: nxt_general = shift_ff[27:0];
                        mafe_pkg::ADDR_FUSE: nxt_fuse = shift_ff;
                        mafe_pkg::ADDR_THRESHOLD: nxt_threshold = shift_ff[16:0];
                        mafe_pkg::ADDR_TEST_CFG: nxt_test_cfg = shift_ff[19:0];
                        default: nxt_shift = shift_ff;
                    endcase
                end
            end
            ST_SKIP: begin
                nxt_state = ST_SKIP;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase

        if (host_in.stop) begin
            nxt_state = ST_IDLE;
        end
        // A start always opens a fresh frame, which ends any skipped write.
        if (host_in.start) begin
            nxt_state = ST_ADDR;
            nxt_shift = '0;
        end
        if (width == mafe_pkg::W_NONE) begin
            width = mafe_pkg::W_NONE;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= ST_IDLE;
            addr_ff <= 4'h0;
            shift_ff <= '0;
            mode_ff <= mafe_pkg::RST_MODE;
            chan_a_ff <= mafe_pkg::RST_CHAN_A;
            chan_b_ff <= mafe_pkg::RST_CHAN_B;
            general_ff <= mafe_pkg::RST_GENERAL;
            result_ff <= '0;
            fuse_ff <= '0;
            cal_ff <= '0;
            trim_ff <= '0;
            threshold_ff <= mafe_pkg::RST_THRESHOLD;
            test_cfg_ff <= mafe_pkg::RST_TEST_CFG;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            shift_ff <= nxt_shift;
            mode_ff <= nxt_mode;
            chan_a_ff <= nxt_chan_a;
            chan_b_ff <= nxt_chan_b;
            general_ff <= nxt_general;
            result_ff <= nxt_result;
            fuse_ff <= nxt_fuse;
            cal_ff <= nxt_cal;
            trim_ff <= nxt_trim;
            threshold_ff <= nxt_threshold;
            test_cfg_ff <= nxt_test_cfg;
        end
    end

    // ************************************************************
    // Decode and outputs
    // ************************************************************
    mafe_cfg_decode mafe_cfg_decode_inst (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .mode_in(mode_ff),
        .general_in(general_ff),
        .gen_ctl_out(gen_ctl_out),
        .mode_dec_out(mode_dec_out)
    );

    assign dout_out = shift_ff[mafe_pkg::SHIFT_W-1];
    assign mode_out = mode_ff;
    assign chan_a_out = chan_a_ff;
    assign chan_b_out = chan_b_ff;
    assign threshold_out = threshold_ff;
    assign test_cfg_out = test_cfg_ff;
    assign fuse_image_out = fuse_ff;
    assign cal_out = cal_ff;
    assign trim_out = trim_ff;

endmodule

//--- tb/mafe_register_bank_properties.sv
// Purpose: Port-level properties of the register bank.
// Assumes: One clock; reset is asynchronous and active low.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ps
module mafe_register_bank_properties (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input mafe_pkg::mafe_host_req_t host_in,
    input wire logic dout_out,
    input wire logic [3:0] mode_out,
    input wire logic [19:0] test_cfg_out,
    input wire logic [109:0] cal_out,
    input mafe_pkg::mafe_gen_ctl_t gen_ctl_out,
    input mafe_pkg::mafe_mode_dec_t mode_dec_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence undef_read;
        host_in.addr_valid && !host_in.write && host_in.addr >= 4'ha;
    endsequence
    sequence word_loaded;
        undef_read ##1 !host_in.shift;
    endsequence
    chk_reset_vals: assert property ($rose(nrst_in) |->
        mode_out == 4'h0 ##1 (gen_ctl_out.pd == 7'h04 && gen_ctl_out.chop_en
        && gen_ctl_out.dechop_en)) else $error("reset defaults wrong");
    chk_mode_commit: assert property (!$stable(mode_out) |->
        $past(host_in.stop) && $past(host_in.addr) == mafe_pkg::ADDR_MODE)
        else $error("mode changed without a commit");
    chk_test_guard: assert property (!$stable(test_cfg_out) |->
        $past(mode_out) == mafe_pkg::MODE_TEST_SPECIAL) else $error("test word changed");
    chk_cal_live: assert property (!$stable(cal_out) |->
        $past(host_in.shift) && cal_out[0] == $past(host_in.din)) else $error("cal not live");
    chk_seq_range: assert property (mode_dec_out.dual_meas ?
        gen_ctl_out.seq_len inside {[5'h01:5'h10]} : gen_ctl_out.seq_len == 5'h00)
        else $error("sequence length wrong");
    chk_mode_flags: assert property (mode_dec_out.test == ($past(mode_out) >= 4'h8)
        && mode_dec_out.dual_meas == ($past(mode_out) == mafe_pkg::MODE_DUAL))
        else $error("mode flags wrong");
    chk_csrc_scale: assert property (gen_ctl_out.csrc_ua ==
        {gen_ctl_out.csrc_code, 3'h0}) else $error("current scale wrong");
    chk_undef_zero: assert property (word_loaded |=> !dout_out)
        else $error("undefined address read not zero");
endmodule
bind mafe_register_bank mafe_register_bank_properties mafe_register_bank_properties_inst (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .host_in(host_in), .dout_out(dout_out),
    .mode_out(mode_out), .test_cfg_out(test_cfg_out), .cal_out(cal_out),
    .gen_ctl_out(gen_ctl_out), .mode_dec_out(mode_dec_out));

//--- tb/mafe_host_model.sv
// Purpose: Host that frames register transfers on the strobe port.
// Assumes: The bank samples on the rising edge; this model moves on the falling one.
// Notes: Idle data shows its inverse level, so a stale bit never looks valid.
`timescale 1ns/1ps
module mafe_host_model (
    input wire logic sys_clk_in,
    input wire logic dout_in,
    output mafe_pkg::mafe_host_req_t host_out
);
    logic [3:0] cur_a = 4'h0;
    logic cur_w = 1'b0;
    initial host_out = '0;
    task automatic put(input logic st, input logic av, input logic sh, input logic d,
                       input logic sp);
        @(negedge sys_clk_in);
        host_out = '{st, av, cur_a, cur_w, sh, sh ? d : ~host_out.din, sp};
    endtask
    // Callers keep to addresses 0 to 11.
    task automatic xfer(input logic [3:0] a, input logic wr, input int n,
                        inout logic [187:0] v);
        cur_a = a;
        cur_w = wr;
        put(1, 0, 0, 0, 0);
        put(0, 1, 0, 0, 0);
        if (n == 0) begin
            // The write is given up right after the address.
            put(0, 0, 0, 0, 0);
            return;
        end
        if (!wr) put(0, 0, 0, 0, 0);
        for (int i = n - 1; i >= 0; i--) begin
            put(0, 0, wr || i > 0, v[i], 0);
            if (!wr) v[i] = dout_in;
        end
        put(0, 0, 0, 0, 1);
        put(0, 0, 0, 0, 0);
    endtask
endmodule

//--- tb/measurement_afe_register_bank_tb.sv
// Purpose: Self-checking bench for the front end register bank.
// Assumes: Inputs change at the falling edge; the host model frames transfers.
// Notes: Random values come from one fixed seed, with corner cases mixed in.
`timescale 1ns/1ps
module measurement_afe_register_bank_tb;
    logic sys_clk_in, nrst_in, result_valid_in, dout;
    logic [17:0] result_in;
    logic [3:0] mode, m;
    logic [16:0] chan_a, chan_b, alarm_threshold;
    logic [19:0] test_cfg, trim;
    logic [109:0] cal;
    logic [187:0] fuse, v, r;
    logic [27:0] g;
    mafe_pkg::mafe_host_req_t host;
    mafe_pkg::mafe_gen_ctl_t gen;
    mafe_pkg::mafe_mode_dec_t dec;
    int failures = 0;
    int tests_run = 0;
    int wid[12] = '{4, 17, 17, 28, 18, 188, 110, 20, 17, 20, 17, 17};
    logic [27:0] rstv[12] = '{1: mafe_pkg::RST_CHAN_A, 2: mafe_pkg::RST_CHAN_B,
        3: mafe_pkg::RST_GENERAL, default: 28'h0};
    mafe_register_bank mafe_register_bank_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .host_in(host), .result_in(result_in), .result_valid_in(result_valid_in),
        .dout_out(dout), .mode_out(mode), .chan_a_out(chan_a), .chan_b_out(chan_b),
        .threshold_out(alarm_threshold), .test_cfg_out(test_cfg), .fuse_image_out(fuse), .cal_out(cal),
        .trim_out(trim), .gen_ctl_out(gen), .mode_dec_out(dec));
    mafe_host_model mafe_host_model_inst (.sys_clk_in(sys_clk_in), .dout_in(dout),
        .host_out(host));
    task automatic check(input string what, input logic [187:0] seen, input logic [187:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic access(input logic [3:0] a, input logic wr, input logic [187:0] d);
        v = d;
        mafe_host_model_inst.xfer(a, wr, wid[a], v);
    endtask
    function automatic mafe_pkg::mafe_gen_ctl_t exp_gen(input logic [27:0] w,
        input logic [3:0] md);
        logic [4:0] s;
        s = (md != mafe_pkg::MODE_DUAL) ? 5'h00 : (w[27:24] == 4'h0) ? 5'h10 : {1'b0, w[27:24]};
        return '{s, w[23], w[22], w[21:16], w[15:11], {w[15:11], 3'h0}, w[10:7], w[6:0]};
    endfunction
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        failures++;
        results();
    end
    initial begin
        nrst_in = 1'b0;
        result_in = 18'h00000;
        result_valid_in = 1'b0;
        void'($urandom(27039));
        repeat (8) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        nrst_in = 1'b1;
        for (int a = 0; a < 12; a++) begin
            access(4'(a), 1'b0, '0);
            check("reset word", v, 188'(rstv[a]));
        end
        check("reset decode", gen, exp_gen(mafe_pkg::RST_GENERAL, 4'h0));
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            m = 4'(i + 8);
            access(4'h0, 1'b1, 188'(m));
            @(negedge sys_clk_in);
            check("mode", {mode, dec}, {m, m[3] ? 9'h001 : 9'h100 >> m});
            if (i == 0) access(4'h9, 1'b1, 188'(3));
        end
        access(4'h0, 1'b1, 188'(1));
        access(4'h9, 1'b1, 188'(0));
        check("test word refused", test_cfg, 20'h00003);
        access(4'h0, 1'b1, 188'(8));
        access(4'h9, 1'b1, 188'(0));
        check("test word taken", test_cfg, 20'h00000);
        access(4'h9, 1'b1, 188'(3));
        access(4'h0, 1'b1, 188'(3));
        mafe_host_model_inst.xfer(4'h9, 1'b1, 0, v);
        access(4'h8, 1'b1, 188'(17'h1a5a5));
        check("write after abort", alarm_threshold, 17'h1a5a5);
        access(4'h1, 1'b1, 188'(17'h1c3c5));
        access(4'h2, 1'b1, 188'(17'h00cc0));
        check("channels", {chan_a, chan_b}, {17'h1c3c5, 17'h00cc0});
        $display("test modes done");
        for (int i = 0; i < 12; i++) begin
            g = (i == 0) ? 28'h0 : (i == 1) ? 28'hfffffff : 28'($urandom);
            m = (i < 2 || $urandom_range(1, 0) == 1) ? 4'h2 : 4'h1;
            access(4'h3, 1'b1, 188'(g));
            access(4'h0, 1'b1, 188'(m));
            @(negedge sys_clk_in);
            check("decode", gen, exp_gen(g, m));
            check("switches", {gen.mux_sw, gen.vbus_sw, gen.pd},
                {g[21:16], g[10:0]});
        end
        $display("test general done");
        r = {$urandom, $urandom, $urandom, $urandom};
        access(4'h0, 1'b1, 188'(1));
        access(4'h6, 1'b1, r);
        access(4'h7, 1'b1, r);
        check("cal trim refused", {cal, trim}, 130'h0);
        access(4'h0, 1'b1, 188'(8));
        access(4'h6, 1'b1, r);
        access(4'h7, 1'b1, r);
        check("cal trim live", {cal, trim}, {r[109:0], r[19:0]});
        access(4'h5, 1'b1, r);
        check("fuse", fuse, r);
        access(4'h7, 1'b0, '0);
        check("trim read", v, 188'(r[19:0]));
        // Analog settling after a trim read, so later results can be trusted.
        repeat (20) @(negedge sys_clk_in);
        result_in = 18'($urandom);
        result_valid_in = 1'b1;
        @(negedge sys_clk_in);
        result_valid_in = 1'b0;
        access(4'h4, 1'b1, ~188'(result_in));
        access(4'h4, 1'b0, '0);
        check("result", v, 188'(result_in));
        access(4'ha, 1'b1, '1);
        access(4'ha, 1'b0, '0);
        check("undefined", v, 188'(0));
        nrst_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        @(negedge sys_clk_in);
        check("second reset", {mode, test_cfg}, 24'h000000);
        $display("test registers done");
        results();
    end
endmodule
